//--- core/temp_limit_monitor.sv
// temperature limit checks, status flags, alert and under-temp retry
module temp_limit_monitor #(
   parameter int RETRY_CYCLES = temp_limit_pkg::RETRY_CYCLES_DFLT,
   parameter int RETRY_W      = 26
) (
   // clock and reset
   input  wire logic                          clock,
   input  wire logic                          rst,
   input  wire logic                          clk_en,
   // host command port
   input  wire temp_limit_pkg::pmbus_req_t    cmd_in,
   output      temp_limit_pkg::pmbus_rsp_t    rsp_q,
   // temperature readings, linear-11
   input  wire temp_limit_pkg::temp_sample_t [temp_limit_pkg::NUM_SRC-1:0]
                                              temp_in,
   input  wire logic [1:0]                    external_sensor_select,
   // output stage control
   input  wire logic                          run_request,
   input  wire logic                          other_fault_shutdown,
   output      logic                          power_enable_q,
   // status
   output      logic [7:0]                    status_temperature_q,
   output      logic                          temp_summary_q,
   output      logic [temp_limit_pkg::NUM_SRC-1:0] sensor_flags_q,
   // open-drain alert
   output      logic                          alert_line_out_q,
   output      logic                          alert_line_oe_n_q
);
   import temp_limit_pkg::*;

   if (RETRY_W < 1 || RETRY_W > 31 ||
       RETRY_CYCLES < 1 || RETRY_CYCLES >= (2 ** RETRY_W))
   begin : g_bad_retry
      $error("RETRY_CYCLES does not fit the retry counter");
   end

   function automatic logic signed [31:0] lin11_to_fix(input logic [15:0] w);
      logic signed [4:0]  n;
      logic signed [31:0] y;
      logic signed [6:0]  sh;
      n  = w[LIN_EXP_HI:LIN_EXP_LO];
      y  = 32'(signed'(w[LIN_MANT_HI:0]));
      sh = 7'(n) + 7'(FIX_FRAC);
      if (sh >= 0)
         return y <<< sh;
      else
         return y >>> (-sh);
   endfunction

   logic [15:0]  ot_warn_q;
   logic [15:0]  ut_warn_q;
   logic [15:0]  under_temp_fault_flag_q;
   logic [7:0]   ut_action_q;
   state_t       state_q;
   state_t       state_d;
   logic [RETRY_W-1:0] retry_cnt_q;

   logic signed [31:0] wr_fix;
   logic         wr_ot_ok;
   logic         wr_ut_ok;
   logic         clear_req;
   logic [NUM_SRC-1:0] src_on;
   logic [NUM_SRC-1:0] ot_hit;
   logic [NUM_SRC-1:0] utw_hit;
   logic [NUM_SRC-1:0] utf_hit;
   logic         utf_any;
   logic [7:0]   status_d;
   logic [NUM_SRC-1:0] sensor_d;
   logic         act_disable;

   // host writes, range checked on the decoded value
   assign wr_fix   = lin11_to_fix(cmd_in.wdata);
   assign wr_ot_ok = wr_fix >= OT_MIN_C * (2 ** FIX_FRAC) &&
                     wr_fix <= OT_MAX_C * (2 ** FIX_FRAC);
   assign wr_ut_ok = wr_fix >= UT_MIN_C * (2 ** FIX_FRAC) &&
                     wr_fix <= UT_MAX_C * (2 ** FIX_FRAC);
   assign clear_req = cmd_in.valid && cmd_in.write &&
                      cmd_in.code == CMD_CLEAR_FAULTS;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         ot_warn_q   <= OT_WARN_RST;
         ut_warn_q   <= UT_WARN_RST;
         under_temp_fault_flag_q  <= UNDER_TEMP_FAULT_FLAG_RST;
         ut_action_q <= UT_ACTION_RST;
      end
      else if (clk_en && cmd_in.valid && cmd_in.write)
      begin
         if (cmd_in.code == CMD_OT_WARN && wr_ot_ok)
            ot_warn_q <= cmd_in.wdata;
         else if (cmd_in.code == CMD_UT_WARN && wr_ut_ok)
            ut_warn_q <= cmd_in.wdata;
         else if (cmd_in.code == CMD_UNDER_TEMP_FAULT_FLAG && wr_ut_ok)
            under_temp_fault_flag_q <= cmd_in.wdata;
         else if (cmd_in.code == CMD_UT_ACTION)
            ut_action_q <= cmd_in.wdata[7:0];
      end
   end

   // host reads and write answers, one cycle after the request
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         rsp_q <= '0;
      else if (clk_en)
      begin
         rsp_q.valid <= cmd_in.valid;
         rsp_q.error <= 1'b0;
         rsp_q.data  <= 16'h0000;
         if (cmd_in.valid)
         begin
            if (cmd_in.code == CMD_OT_WARN)
            begin
               rsp_q.data  <= ot_warn_q;
               rsp_q.error <= cmd_in.write && !wr_ot_ok;
            end
            else if (cmd_in.code == CMD_UT_WARN)
            begin
               rsp_q.data  <= ut_warn_q;
               rsp_q.error <= cmd_in.write && !wr_ut_ok;
            end
            else if (cmd_in.code == CMD_UNDER_TEMP_FAULT_FLAG)
            begin
               rsp_q.data  <= under_temp_fault_flag_q;
               rsp_q.error <= cmd_in.write && !wr_ut_ok;
            end
            else if (cmd_in.code == CMD_UT_ACTION)
               rsp_q.data <= {8'h00, ut_action_q};
            else if (cmd_in.code == CMD_CLEAR_FAULTS)
               rsp_q.error <= !cmd_in.write;
            else
               rsp_q.error <= 1'b1;
         end
      end
   end

   // per-sensor limit comparison
   generate
      for (genvar i = 0; i < NUM_SRC; i++)
      begin : g_src
         logic signed [31:0] t_fix;
         if (i == 0)
         begin : g_int
            assign src_on[i] = 1'b1;
         end
         else
         begin : g_ext
            assign src_on[i] = external_sensor_select[i-1];
         end
         assign t_fix = lin11_to_fix(temp_in[i].value);
         assign ot_hit[i]  = src_on[i] && temp_in[i].valid &&
                             t_fix > lin11_to_fix(ot_warn_q);
         assign utw_hit[i] = src_on[i] && temp_in[i].valid &&
                             t_fix < lin11_to_fix(ut_warn_q);
         assign utf_hit[i] = src_on[i] && temp_in[i].valid &&
                             t_fix < lin11_to_fix(under_temp_fault_flag_q);
      end
   endgenerate

   assign utf_any = |utf_hit;

   // sticky flags; a new event wins over clear-faults
   always_comb
   begin
      status_d = status_temperature_q & {8{!clear_req}};
      status_d[STAT_OT_WARN]  = status_d[STAT_OT_WARN]  | (|ot_hit);
      status_d[STAT_UT_WARN]  = status_d[STAT_UT_WARN]  | (|utw_hit);
      status_d[STAT_UNDER_TEMP_FAULT_FLAG] = status_d[STAT_UNDER_TEMP_FAULT_FLAG] | utf_any;
      sensor_d = (sensor_flags_q & {NUM_SRC{!clear_req}}) |
                 ot_hit | utw_hit | utf_hit;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         status_temperature_q <= 8'h00;
         sensor_flags_q       <= '0;
         temp_summary_q       <= 1'b0;
      end
      else if (clk_en)
      begin
         status_temperature_q <= status_d;
         sensor_flags_q       <= sensor_d;
         temp_summary_q       <= |status_d;
      end
   end

   // alert pulled low while any flag stands
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         alert_line_out_q  <= 1'b0;
         alert_line_oe_n_q <= 1'b1;
      end
      else if (clk_en)
      begin
         alert_line_out_q  <= 1'b0;
         alert_line_oe_n_q <= !(|status_d);
      end
   end

   // under-temp fault response
   assign act_disable =
      ut_action_q[ACT_MODE_HI:ACT_MODE_LO] == MODE_DISABLE_RETRY;

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_OFF:
            if (run_request && !other_fault_shutdown)
               state_d = ST_RUN;
         ST_RUN:
            if (!run_request || other_fault_shutdown)
               state_d = ST_OFF;
            else if (utf_any && act_disable)
            begin
               if (ut_action_q[ACT_RETRY_HI:ACT_RETRY_LO] == RETRY_FOREVER)
                  state_d = ST_WAIT;
               else
                  state_d = ST_LATCHED;
            end
         ST_WAIT:
            if (!run_request || other_fault_shutdown)
               state_d = ST_OFF;
            else if (retry_cnt_q == '0)
               state_d = ST_RUN;
         ST_LATCHED:
            state_d = ST_LATCHED;
         default:
            state_d = ST_OFF;
      endcase
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state_q        <= ST_OFF;
         power_enable_q <= 1'b0;
      end
      else if (clk_en)
      begin
         state_q        <= state_d;
         power_enable_q <= state_d == ST_RUN;
      end
   end

   // restart interval counter
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         retry_cnt_q <= '0;
      else if (clk_en)
      begin
         if (state_q != ST_WAIT)
            retry_cnt_q <= RETRY_W'(RETRY_CYCLES - 1);
         else if (retry_cnt_q != '0)
            retry_cnt_q <= retry_cnt_q - 1'b1;
      end
   end

   // checks
   default clocking cb @(posedge clock iff clk_en);
   endclocking
   default disable iff (rst);

   sequence s_enter_wait;
      state_q == ST_RUN ##1 state_q == ST_WAIT;
   endsequence
   sequence s_wait_loaded;
      retry_cnt_q == RETRY_W'(RETRY_CYCLES - 1) && !power_enable_q;
   endsequence

   property p_ot_flags;
      ot_hit[1] |=> status_temperature_q[STAT_OT_WARN] && temp_summary_q
                    && sensor_flags_q[1];
   endproperty
   a_ot_flags: assert property (p_ot_flags)
      else $error("over-temp warning flags not set");
   property p_src_select;
      !external_sensor_select[0] && !sensor_flags_q[1] && !clear_req
         |=> !sensor_flags_q[1];
   endproperty
   a_src_select: assert property (p_src_select)
      else $error("deselected sensor flagged");
   property p_utw_flags;
      utw_hit[0] |=> status_temperature_q[STAT_UT_WARN]
                     && sensor_flags_q[0] && !alert_line_oe_n_q;
   endproperty
   a_utw_flags: assert property (p_utw_flags)
      else $error("under-temp warning not reported");
   property p_set_wins;
      clear_req && utf_any |=> status_temperature_q[STAT_UNDER_TEMP_FAULT_FLAG];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("fault event lost against clear");
   property p_fault_sticky;
      status_temperature_q[STAT_UNDER_TEMP_FAULT_FLAG] && !clear_req
         |=> status_temperature_q[STAT_UNDER_TEMP_FAULT_FLAG] && !alert_line_oe_n_q;
   endproperty
   a_fault_sticky: assert property (p_fault_sticky)
      else $error("fault flag dropped without clear");
   property p_disable;
      state_q == ST_RUN && run_request && !other_fault_shutdown
         && utf_any && act_disable |=> !power_enable_q;
   endproperty
   a_disable: assert property (p_disable)
      else $error("output not disabled on under-temp fault");
   property p_latched;
      state_q == ST_LATCHED |=> state_q == ST_LATCHED && !power_enable_q;
   endproperty
   a_latched: assert property (p_latched)
      else $error("latched shutdown released");
   property p_retry_load;
      s_enter_wait |-> s_wait_loaded;
   endproperty
   a_retry_load: assert property (p_retry_load)
      else $error("retry interval not loaded");
   property p_retry_end;
      state_q == ST_WAIT && retry_cnt_q == '0 && run_request
         && !other_fault_shutdown |=> power_enable_q;
   endproperty
   a_retry_end: assert property (p_retry_end)
      else $error("restart not attempted after interval");
   property p_retry_stop;
      state_q == ST_WAIT && !run_request |=> (state_q == ST_OFF)[*2];
   endproperty
   a_retry_stop: assert property (p_retry_stop)
      else $error("retry continued after off command");
   property p_limit_range;
      cmd_in.valid && cmd_in.write && cmd_in.code == CMD_OT_WARN && !wr_ot_ok
         |=> $stable(ot_warn_q) && rsp_q.error;
   endproperty
   a_limit_range: assert property (p_limit_range)
      else $error("out-of-range limit accepted");
endmodule // temp_limit_monitor

//--- core/temp_limit_pkg.sv
// constants and types for the temperature limit monitor
package temp_limit_pkg;

   // timing
   localparam int CLOCK_MHZ     = 250;
   localparam int RETRY_TIME_MS = 210;
   localparam int RETRY_CYCLES_DFLT = RETRY_TIME_MS * 1000 * CLOCK_MHZ;

   // command codes
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_OT_WARN      = 8'h51;
   localparam logic [7:0] CMD_UT_WARN      = 8'h52;
   localparam logic [7:0] CMD_UNDER_TEMP_FAULT_FLAG     = 8'h53;
   localparam logic [7:0] CMD_UT_ACTION    = 8'h54;

   // reset values
   localparam logic [15:0] OT_WARN_RST   = 16'hEB70;
   localparam logic [15:0] UT_WARN_RST   = 16'hDC40;
   localparam logic [15:0] UNDER_TEMP_FAULT_FLAG_RST  = 16'hE530;
   localparam logic [7:0]  UT_ACTION_RST = 8'h80;

   // action byte fields
   localparam int ACT_MODE_HI  = 7;
   localparam int ACT_MODE_LO  = 6;
   localparam int ACT_RETRY_HI = 5;
   localparam int ACT_RETRY_LO = 3;
   localparam logic [1:0] MODE_DISABLE_RETRY = 2'h2;
   localparam logic [2:0] RETRY_FOREVER      = 3'h7;

   // linear-11 layout and fixed-point compare scale
   localparam int LIN_EXP_HI  = 15;
   localparam int LIN_EXP_LO  = 11;
   localparam int LIN_MANT_HI = 10;
   localparam int FIX_FRAC    = 4;

   // accepted limit ranges, degrees Celsius
   localparam int OT_MIN_C = 0;
   localparam int OT_MAX_C = 175;
   localparam int UT_MIN_C = -55;
   localparam int UT_MAX_C = 25;

   // temperature status byte bits
   localparam int STAT_OT_WARN  = 6;
   localparam int STAT_UT_WARN  = 5;
   localparam int STAT_UNDER_TEMP_FAULT_FLAG = 4;

   // sensors: 0 internal, 1 external 0, 2 external 1
   localparam int NUM_SRC = 3;

   typedef struct packed {
      logic        valid;
      logic [15:0] value;
   } temp_sample_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  code;
      logic [15:0] wdata;
   } pmbus_req_t;

   typedef struct packed {
      logic        valid;
      logic        error;
      logic [15:0] data;
   } pmbus_rsp_t;

   typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_LATCHED, ST_WAIT} state_t;

endpackage

//--- sim/pmbus_host_model.sv
// host model issuing command requests and taking the replies
module pmbus_host_model (
   // clock
   input  wire logic                       clock,
   // command path
   output      temp_limit_pkg::pmbus_req_t cmd_out,
   input  wire temp_limit_pkg::pmbus_rsp_t rsp_in
);
   timeunit 1ns;
   timeprecision 100ps;
   import temp_limit_pkg::*;

   initial cmd_out = '0;

   // one request per call; released fields carry the inverse pattern
   task automatic xfer(input logic wr, input logic [7:0] code,
      input logic [15:0] wdata, output logic [15:0] data, output logic err);
      @(negedge clock);
      cmd_out.valid = 1'b1;
      cmd_out.write = wr;
      cmd_out.code  = code;
      cmd_out.wdata = wdata;
      @(negedge clock);
      cmd_out = '{valid: 1'b0, write: ~wr, code: ~code, wdata: ~wdata};
      data = rsp_in.data;
      err  = (rsp_in.valid === 1'b1) ? rsp_in.error : 1'bx;
   endtask
endmodule // pmbus_host_model

//--- sim/temp_limit_monitor_bench.sv
// self-checking bench for the temperature limit monitor
module temp_limit_monitor_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import temp_limit_pkg::*;

   localparam int RETRY = 20;
   localparam int LIMIT = 5000;

   logic                       clock;
   logic                       rst;
   logic                       clk_en;
   pmbus_req_t                 cmd;
   pmbus_rsp_t                 rsp;
   temp_sample_t [NUM_SRC-1:0] temp_in;
   logic [1:0]                 sensor_select;
   logic                       run_request;
   logic                       other_fault;
   logic                       power_enable;
   logic [7:0]                 status;
   logic                       summary;
   logic [2:0]                 sensor_flags;
   logic                       alert_out;
   logic                       alert_oe_n;
   int                         n_fail;
   int                         check_count;
   int                         cycles;
   int                         m;
   logic [7:0]                 modes [3] = '{8'h00, 8'h78, 8'hC0};
   // expected contents of the four limit and action words
   logic [15:0]                shadow [4];

   pmbus_host_model host (
      .clock   (clock),
      .cmd_out (cmd),
      .rsp_in  (rsp)
   );

   temp_limit_monitor #(.RETRY_CYCLES(RETRY)) uut (
      .clock                  (clock),
      .rst                    (rst),
      .clk_en                 (clk_en),
      .cmd_in                 (cmd),
      .rsp_q                  (rsp),
      .temp_in                (temp_in),
      .external_sensor_select (sensor_select),
      .run_request            (run_request),
      .other_fault_shutdown   (other_fault),
      .power_enable_q         (power_enable),
      .status_temperature_q   (status),
      .temp_summary_q         (summary),
      .sensor_flags_q         (sensor_flags),
      .alert_line_out_q       (alert_out),
      .alert_line_oe_n_q      (alert_oe_n)
   );

   initial
   begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   always @(posedge clock)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         n_fail++;
         $display("FAIL %0t run did not finish", $time);
         complete_run();
      end
   end

   // linear-11 with zero exponent, whole degrees
   function automatic logic [15:0] lin(input int c);
      return {5'h00, c[10:0]};
   endfunction

   task automatic fail_msg(input string s);
      n_fail++;
      $display("FAIL %0t %s", $time, s);
   endtask

   task automatic check_rsp(input logic [15:0] d, input logic e,
      input logic [15:0] ed, input logic ee);
      check_count++;
      if (d !== ed || e !== ee)
         fail_msg($sformatf("reply %h/%b expected %h/%b", d, e, ed, ee));
   endtask

   task automatic check_status(input logic [7:0] es, input logic [2:0] ec);
      check_count++;
      if (status !== es || sensor_flags !== ec || alert_out !== 1'b0 ||
         summary !== (es != 8'h00) || alert_oe_n !== (es == 8'h00))
         fail_msg($sformatf("flags %h/%b expected %h/%b", status,
            sensor_flags, es, ec));
   endtask

   task automatic check_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp)
         fail_msg("power or count mismatch");
   endtask

   task automatic rd(input logic [7:0] c, input logic [15:0] ed);
      logic [15:0] d;
      logic        e;
      host.xfer(1'b0, c, 16'h0000, d, e);
      check_rsp(d, e, ed, 1'b0);
   endtask

   // write replies echo the word held before the write
   task automatic wr(input logic [7:0] c, input logic [15:0] w,
      input logic ee);
      logic [15:0] d;
      logic        e;
      logic [15:0] ed;
      int          idx;
      idx = int'(c) - int'(CMD_OT_WARN);
      ed  = (idx >= 0 && idx < 4) ? shadow[idx] : 16'h0000;
      host.xfer(1'b1, c, w, d, e);
      check_rsp(d, e, ed, ee);
      if (!ee && idx >= 0 && idx < 4)
         shadow[idx] = (c == CMD_UT_ACTION) ? {8'h00, w[7:0]} : w;
   endtask

   task automatic send_temp(input int i, input int c);
      @(negedge clock);
      temp_in[i].valid = 1'b1;
      temp_in[i].value = lin(c);
      @(negedge clock);
      temp_in[i].valid = 1'b0;
      temp_in[i].value = ~lin(c);
   endtask

   task automatic clear_all;
      wr(CMD_CLEAR_FAULTS, 16'h0000, 1'b0);
      check_status(8'h00, 3'b000);
   endtask

   task automatic reset_pulse(input int n);
      @(negedge clock);
      rst = 1'b1;
      shadow = '{OT_WARN_RST, UT_WARN_RST, UNDER_TEMP_FAULT_FLAG_RST,
                 {8'h00, UT_ACTION_RST}};
      repeat (n) @(negedge clock);
      rst = 1'b0;
      repeat (3) @(negedge clock);
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      n_fail = 0;
      check_count = 0;
      cycles = 0;
      clk_en = 1'b1;
      temp_in = '0;
      sensor_select = 2'b00;
      run_request = 1'b1;
      other_fault = 1'b0;
      rst = 1'b1;
      reset_pulse(10);
      check_status(8'h00, 3'b000);
      rd(8'h51, 16'hEB70);
      rd(8'h52, 16'hDC40);
      rd(8'h53, 16'hE530);
      rd(8'h54, 16'h0080);
      wr(8'h60, 16'h0000, 1'b1);
      $display("test reset values done");
      wr(8'h51, lin(176), 1'b1);
      rd(8'h51, 16'hEB70);
      wr(8'h51, lin(175), 1'b0);
      wr(8'h51, lin(100), 1'b0);
      rd(8'h51, lin(100));
      wr(8'h52, lin(-56), 1'b1);
      wr(8'h52, lin(26), 1'b1);
      rd(8'h52, 16'hDC40);
      wr(8'h52, lin(-20), 1'b0);
      wr(8'h53, lin(-55), 1'b0);
      wr(8'h53, 16'hE530, 1'b0);
      rd(8'h53, 16'hE530);
      $display("test limit words done");
      send_temp(1, 150);
      check_status(8'h00, 3'b000);
      sensor_select = 2'b01;
      send_temp(2, 150);
      check_status(8'h00, 3'b000);
      send_temp(1, 100);
      check_status(8'h00, 3'b000);
      // samples are ignored while the clock enable is low
      clk_en = 1'b0;
      send_temp(1, 101);
      check_status(8'h00, 3'b000);
      clk_en = 1'b1;
      send_temp(1, 101);
      check_status(8'h40, 3'b010);
      clear_all();
      send_temp(0, -20);
      check_status(8'h00, 3'b000);
      send_temp(0, -21);
      check_status(8'h20, 3'b001);
      clear_all();
      $display("test warnings done");
      foreach (modes[k])
      begin
         wr(8'h54, {8'h00, modes[k]}, 1'b0);
         send_temp(0, -46);
         check_status(8'h30, 3'b001);
         repeat (2) @(negedge clock);
         check_bit(power_enable, 1'b1);
         clear_all();
      end
      $display("test unused modes done");
      // clear-faults and a fault sample on the same edge
      fork
         wr(CMD_CLEAR_FAULTS, 16'h0000, 1'b0);
         send_temp(0, -46);
      join
      check_status(8'h30, 3'b001);
      clear_all();
      wr(8'h54, 16'h0080, 1'b0);
      sensor_select = 2'b11;
      send_temp(2, -46);
      check_status(8'h30, 3'b100);
      repeat (RETRY + 10) @(negedge clock);
      check_bit(power_enable, 1'b0);
      clear_all();
      check_bit(power_enable, 1'b0);
      reset_pulse(2);
      check_bit(power_enable, 1'b1);
      rd(8'h51, 16'hEB70);
      $display("test latched shutdown done");
      wr(8'h54, 16'h00B8, 1'b0);
      send_temp(1, -60);
      @(negedge clock);
      check_bit(power_enable, 1'b0);
      m = 2;
      while (power_enable !== 1'b1 && m < 200)
      begin
         @(negedge clock);
         m++;
      end
      check_bit(m == RETRY + 1, 1'b1);
      // off command while waiting to restart
      send_temp(1, -60);
      run_request = 1'b0;
      repeat (RETRY + 5) @(negedge clock);
      check_bit(power_enable, 1'b0);
      run_request = 1'b1;
      repeat (3) @(negedge clock);
      check_bit(power_enable, 1'b1);
      other_fault = 1'b1;
      repeat (2) @(negedge clock);
      check_bit(power_enable, 1'b0);
      other_fault = 1'b0;
      $display("test retry done");
      complete_run();
   end
endmodule // temp_limit_monitor_bench
